// >>> inc/dpot_defs.svh
`ifndef DPOT_DEFS_SVH
`define DPOT_DEFS_SVH

// Register addresses on the serial link.
`define DPOT_ADDR_WIPER 8'h00
`define DPOT_ADDR_RSVD 8'h01
`define DPOT_ADDR_ACCSEL 8'h02
// Access-select values and the significant bit.
`define DPOT_ACCSEL_RESET 8'h00
`define DPOT_ACCSEL_VOLATILE 8'h80
`define DPOT_ACCSEL_BIT 7
// Direction bit of the identification byte.
`define DPOT_DIR_READ 1'b1
// Timing of the internal non-volatile write cycle and the power-up recall.
`define DPOT_NVWRITE_US 5000
`define DPOT_POWERUP_US 100
`define DPOT_CLK_MHZ 20

`endif

// >>> inc/dpot_pkg.sv
`default_nettype none
package dpot_pkg;

  // Serial-side state of the slave.
  typedef enum logic [2:0] {
    DPOT_IDLE,
    DPOT_RX,
    DPOT_ACK,
    DPOT_TX,
    DPOT_MACK,
    DPOT_SKIP
  } dpot_link_e;

  // Byte phase within a transfer.
  typedef enum logic [1:0] {
    DPOT_PH_ID,
    DPOT_PH_ADDR,
    DPOT_PH_DATA
  } dpot_phase_e;

  // Core-side storage state.
  typedef enum logic [1:0] {
    DPOT_BOOT,
    DPOT_READY,
    DPOT_NVBUSY
  } dpot_core_e;

  // A write captured on the link, carried to the core.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } dpot_wr_s;

endpackage : dpot_pkg
`default_nettype wire

// >>> core/dpot_slave.sv
`timescale 1ns/100ps
`default_nettype none
`include "dpot_defs.svh"
module dpot_slave #(
  parameter int unsigned NVWRITE_CYCLES = `DPOT_NVWRITE_US * `DPOT_CLK_MHZ,
  parameter int unsigned POWERUP_CYCLES = `DPOT_POWERUP_US * `DPOT_CLK_MHZ,
  parameter logic [6:0] DEVICE_CODE = 7'h3A, // Arbitrary value.
  parameter logic [7:0] STORE_INIT = 8'h80
) (
  // Core clock, reset and enable.
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  // Serial link; the serial clock is the link domain clock.
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Potentiometer side.
  output logic [7:0] wiper_setting,
  output logic [7:0] powerup_value_store,
  output logic nv_busy
);

  // ****************************************************************
  // Core domain: storage, power-up recall and write cycle
  // ****************************************************************

  localparam int unsigned CW = $clog2(NVWRITE_CYCLES + POWERUP_CYCLES + 2);

  dpot_pkg::dpot_core_e core_q, core_d;
  logic [CW-1:0] cnt_q;
  logic [7:0] wiper_q, store_q, accsel_q;
  logic [7:0] nv_mem_q;
  logic [2:0] wtog_s_q, stog_s_q;
  logic w_evt, s_evt;
  logic busy_lvl;
  logic pend_nv_q;

  // Link-side registers declared here for use in the crossing.
  logic wtog_q, stop_tog_q;
  dpot_pkg::dpot_wr_s wr_q;

  // Toggle events from the link pass three stages; act when last two differ.
  assign w_evt = wtog_s_q[2] ^ wtog_s_q[1];
  assign s_evt = stog_s_q[2] ^ stog_s_q[1];

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wtog_s_q <= 3'h0;
      stog_s_q <= 3'h0;
    end
    else if (clk_en)
    begin
      wtog_s_q <= {wtog_s_q[1:0], wtog_q};
      stog_s_q <= {stog_s_q[1:0], stop_tog_q};
    end
  end

  // Core next state and write-cycle decision.
  always_comb
  begin
    core_d = core_q;
    case (core_q)
      dpot_pkg::DPOT_BOOT: if (cnt_q == CW'(POWERUP_CYCLES - 1)) core_d = dpot_pkg::DPOT_READY;
      dpot_pkg::DPOT_READY: if (s_evt && pend_nv_q) core_d = dpot_pkg::DPOT_NVBUSY;
      dpot_pkg::DPOT_NVBUSY: if (cnt_q == CW'(NVWRITE_CYCLES - 1)) core_d = dpot_pkg::DPOT_READY;
      default: core_d = dpot_pkg::DPOT_BOOT;
    endcase
  end

  assign busy_lvl = (core_q != dpot_pkg::DPOT_READY);

  // Storage update and cycle counting.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      core_q <= dpot_pkg::DPOT_BOOT;
      cnt_q <= '0;
      wiper_q <= 8'h00;
      store_q <= STORE_INIT;
      nv_mem_q <= STORE_INIT;
      accsel_q <= `DPOT_ACCSEL_RESET;
      pend_nv_q <= 1'b0;
    end
    else if (clk_en)
    begin
      core_q <= core_d;
      cnt_q <= (core_d != core_q) ? '0 : cnt_q + 1'b1;
      if (core_q == dpot_pkg::DPOT_BOOT && core_d == dpot_pkg::DPOT_READY)
        wiper_q <= nv_mem_q;
      if (core_q == dpot_pkg::DPOT_NVBUSY && core_d == dpot_pkg::DPOT_READY)
        nv_mem_q <= store_q;
      if (s_evt)
        pend_nv_q <= 1'b0;
      if (w_evt && core_q == dpot_pkg::DPOT_READY)
      begin
        if (wr_q.addr == `DPOT_ADDR_WIPER)
        begin
          wiper_q <= wr_q.data;
          if (!accsel_q[`DPOT_ACCSEL_BIT])
          begin
            store_q <= wr_q.data;
            pend_nv_q <= 1'b1;
          end
        end
        else if (wr_q.addr == `DPOT_ADDR_ACCSEL)
          accsel_q <= {wr_q.data[`DPOT_ACCSEL_BIT], 7'h00};
      end
    end
  end

  assign wiper_setting = wiper_q;
  assign powerup_value_store = nv_mem_q;
  assign nv_busy = busy_lvl;

  // ****************************************************************
  // Link domain: start/stop detection, shifting and acknowledge
  // ****************************************************************

  logic [2:0] busy_s_q;
  logic link_busy;
  logic [7:0] rd_word;
  dpot_pkg::dpot_link_e lst_q;
  dpot_pkg::dpot_phase_e ph_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic [7:0] addr_q;
  logic drive_q;
  logic start_tog_q, start_seen_q, stop_seen_q;
  logic start_hit, stop_hit;

  // Busy level crosses into the link domain, clocked on the serial clock.
  always_ff @(posedge scl or negedge nrst)
  begin
    if (!nrst)
      busy_s_q <= 3'h7;
    else
      busy_s_q <= {busy_s_q[1:0], busy_lvl};
  end
  assign link_busy = busy_s_q[2] | busy_s_q[1];

  // Read data: select by access-select; held static while the link reads it.
  assign rd_word = (addr_q == `DPOT_ADDR_ACCSEL) ? accsel_q :
    (accsel_q[`DPOT_ACCSEL_BIT] ? wiper_q : nv_mem_q);

  // Start and stop are data edges while the clock is high; toggles reach scl.
  always_ff @(negedge sda_in or negedge nrst)
  begin
    if (!nrst)
      start_tog_q <= 1'b0;
    else if (scl)
      start_tog_q <= ~start_tog_q;
  end

  // The core syncs this toggle itself, as the serial clock stands still after a stop.
  always_ff @(posedge sda_in or negedge nrst)
  begin
    if (!nrst)
      stop_tog_q <= 1'b0;
    else if (scl)
      stop_tog_q <= ~stop_tog_q;
  end

  assign start_hit = (start_tog_q != start_seen_q) && !link_busy;
  assign stop_hit = (stop_tog_q != stop_seen_q);

  // Receive on the rising serial edge, most significant bit first.
  always_ff @(posedge scl or negedge nrst)
  begin
    if (!nrst)
    begin
      lst_q <= dpot_pkg::DPOT_IDLE;
      ph_q <= dpot_pkg::DPOT_PH_ID;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      addr_q <= 8'h00;
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
      wr_q <= '0;
      wtog_q <= 1'b0;
    end
    else
    begin
      start_seen_q <= start_tog_q;
      stop_seen_q <= stop_tog_q;
      if (link_busy)
        lst_q <= dpot_pkg::DPOT_IDLE;
      else if (start_hit)
      begin
        lst_q <= dpot_pkg::DPOT_RX;
        ph_q <= dpot_pkg::DPOT_PH_ID;
        sh_q <= {7'h00, sda_in};
        bit_q <= 4'h1;
      end
      else if (stop_hit)
        lst_q <= dpot_pkg::DPOT_IDLE;
      else
        case (lst_q)
          dpot_pkg::DPOT_RX:
          begin
            sh_q <= {sh_q[6:0], sda_in};
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7)
            begin
              if (ph_q == dpot_pkg::DPOT_PH_ID && sh_q[6:0] != DEVICE_CODE)
                lst_q <= dpot_pkg::DPOT_SKIP;
              else
                lst_q <= dpot_pkg::DPOT_ACK;
            end
          end
          dpot_pkg::DPOT_ACK:
          begin
            bit_q <= 4'h0;
            case (ph_q)
              dpot_pkg::DPOT_PH_ID:
              begin
                ph_q <= dpot_pkg::DPOT_PH_ADDR;
                lst_q <= (sh_q[0] == `DPOT_DIR_READ) ?
                  dpot_pkg::DPOT_TX : dpot_pkg::DPOT_RX;
              end
              dpot_pkg::DPOT_PH_ADDR:
              begin
                addr_q <= sh_q;
                ph_q <= dpot_pkg::DPOT_PH_DATA;
                lst_q <= dpot_pkg::DPOT_RX;
              end
              default:
              begin
                wr_q <= '{addr: addr_q, data: sh_q};
                wtog_q <= ~wtog_q;
                lst_q <= dpot_pkg::DPOT_SKIP;
              end
            endcase
          end
          dpot_pkg::DPOT_TX:
          begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7)
              lst_q <= dpot_pkg::DPOT_MACK;
          end
          dpot_pkg::DPOT_MACK: lst_q <= dpot_pkg::DPOT_SKIP;
          default: lst_q <= lst_q;
        endcase
    end
  end

  // Drive changes on the falling serial edge so data is stable while high.
  always_ff @(negedge scl or negedge nrst)
  begin
    if (!nrst)
    begin
      drive_q <= 1'b0;
      sda_out <= 1'b1;
    end
    else if (link_busy)
    begin
      drive_q <= 1'b0;
      sda_out <= 1'b1;
    end
    else if (lst_q == dpot_pkg::DPOT_ACK)
    begin
      drive_q <= 1'b1;
      sda_out <= 1'b0;
    end
    else if (lst_q == dpot_pkg::DPOT_TX)
    begin
      drive_q <= 1'b1;
      sda_out <= rd_word[3'(4'h7 - bit_q)];
    end
    else
    begin
      drive_q <= 1'b0;
      sda_out <= 1'b1;
    end
  end

  assign sda_oe = drive_q;

  // ****************************************************************
  // Checks
  // ****************************************************************

  a_accsel_reset: assert property (@(posedge clock) disable iff (!nrst)
    $rose(nrst) |-> accsel_q == `DPOT_ACCSEL_RESET) else $error("select not zero");
  a_accsel_bits: assert property (@(posedge clock) disable iff (!nrst)
    accsel_q[6:0] == 7'h00) else $error("select low bits set");
  a_busy_release: assert property (@(negedge scl) disable iff (!nrst)
    link_busy |=> !sda_oe) else $error("pin driven while busy");
  a_nv_launch: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && core_q == dpot_pkg::DPOT_READY && s_evt && pend_nv_q)
    |=> core_q == dpot_pkg::DPOT_NVBUSY) else $error("write cycle not launched");
  a_vol_standby: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && core_q == dpot_pkg::DPOT_READY && s_evt && !pend_nv_q)
    |=> core_q == dpot_pkg::DPOT_READY) else $error("volatile stop left standby");
  a_ack_low: assert property (@(negedge scl) disable iff (!nrst)
    (lst_q == dpot_pkg::DPOT_ACK && !link_busy) |=> (sda_oe && !sda_out)) else $error("ack not low");
  a_skip_quiet: assert property (@(negedge scl) disable iff (!nrst)
    lst_q == dpot_pkg::DPOT_SKIP |=> !sda_oe) else $error("driven while ignoring");
  a_recall: assert property (@(posedge clock) disable iff (!nrst)
    (clk_en && core_q == dpot_pkg::DPOT_BOOT && core_d == dpot_pkg::DPOT_READY)
    |=> wiper_q == nv_mem_q) else $error("power-up recall missed");

endmodule : dpot_slave
`default_nettype wire

// >>> bench/dpot_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Bus master model on the serial link.
// ****************************************
module dpot_master_model #(
  parameter logic [6:0] ID = 7'h00
) (
  // Open-drain data line, clock driven both ways; the bench resolves the wire.
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam int HALF = 32;

  // Both lines are released and the clock stands high between frames.
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One clock pulse; data moves only while the clock is low.
  task automatic clk_bit(input logic b, output logic seen);
    sda_low = ~b;
    #HALF scl = 1'b1;
    #HALF seen = sda;
    scl = 1'b0;
  endtask : clk_bit

  // Start, or repeated start when the clock is already low.
  task automatic start();
    sda_low = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda_low = 1'b1;
    #HALF scl = 1'b0;
  endtask : start

  // Clock pulses with data released let the slave see a busy level fall.
  task automatic idle();
    repeat (3)
    begin
      scl = 1'b0;
      #HALF scl = 1'b1;
      #HALF;
    end
  endtask : idle

  // Stop leaves both lines released.
  task automatic stop();
    sda_low = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask : stop

  // Sends one byte, then releases the line for the answer.
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : send

  // Full write of one byte to one address.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [2:0] k);
    start();
    send({ID, 1'b0}, k[2]);
    send(a, k[1]);
    send(d, k[0]);
    stop();
  endtask : wr

  // Read: address set, repeated start, then one byte in and stop.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [2:0] k);
    logic s;
    start();
    send({ID, 1'b0}, k[2]);
    send(a, k[1]);
    start();
    send({ID, 1'b1}, k[0]);
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    stop();
  endtask : rd
endmodule : dpot_master_model
`default_nettype wire

// >>> bench/tb_dpot_slave.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Self-checking bench for the serial slave.
// ****************************************
module tb_dpot_slave;
  localparam logic [6:0] ID = 7'h3A; // Arbitrary value.
  typedef struct packed {
    logic wr;
    logic [7:0] sel;
    logic [7:0] data;
    logic [7:0] wiper;
    logic [7:0] store;
    logic busy;
  } dpot_row_s;
  dpot_row_s rows [5] = '{
    '{1'b1, 8'h00, 8'hFF, 8'hFF, 8'hFF, 1'b1},
    '{1'b1, 8'h80, 8'h3C, 8'h3C, 8'hFF, 1'b0},
    '{1'b1, 8'h80, 8'h00, 8'h00, 8'hFF, 1'b0},
    '{1'b0, 8'h00, 8'h00, 8'h00, 8'hFF, 1'b0},
    '{1'b1, 8'h00, 8'hA5, 8'hA5, 8'hA5, 1'b1}};
  logic clock, nrst, scl, sda_low, sda_out, sda_oe, nv_busy;
  logic [7:0] wiper_setting, powerup_value_store, rd;
  logic [2:0] ak;
  int fails = 0;
  int comparisons = 0;
  wire logic sda;

  // Pulled up unless a party pulls it low.
  assign sda = (sda_low | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;

  dpot_slave #(.NVWRITE_CYCLES(20), .POWERUP_CYCLES(10), .DEVICE_CODE(ID)) u_dpot_slave (
    .clock(clock), .nrst(nrst), .clk_en(1'b1), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .wiper_setting(wiper_setting),
    .powerup_value_store(powerup_value_store), .nv_busy(nv_busy));
  dpot_master_model #(.ID(ID)) u_dpot_master_model (.scl(scl), .sda_low(sda_low), .sda(sda));

  // Core clock, 50 ns period.
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Compares one value and counts it.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // Waits a bounded time for the busy flag to fall, then clocks the link while idle.
  task automatic wait_idle(input int lim);
    int n = 0;
    while (nv_busy !== 1'b0 && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    check({7'h0, nv_busy}, 8'h00);
    if (nv_busy !== 1'b0)
      print_verdict();
    u_dpot_master_model.idle();
  endtask : wait_idle

  // Reset for 12 cycles, then the power-up recall.
  task automatic do_reset();
    @(posedge clock);
    #1 nrst = 1'b0;
    repeat (12) @(posedge clock);
    check({6'h0, sda_oe, nv_busy}, 8'h01);
    check(powerup_value_store, 8'h80);
    #1 nrst = 1'b1;
    wait_idle(400);
    check({7'h0, nv_busy}, 8'h00);
    if (nv_busy !== 1'b0)
      print_verdict();
    check(wiper_setting, 8'h80);
    $display("test reset done");
  endtask : do_reset

  // Main sequence.
  initial
  begin
    nrst = 1'b0;
    do_reset();
    foreach (rows[i])
    begin
      u_dpot_master_model.wr(8'h02, rows[i].sel, ak);
      check({5'h0, ak}, 8'h07);
      if (rows[i].wr)
        u_dpot_master_model.wr(8'h00, rows[i].data, ak);
      repeat (10) @(posedge clock);
      #1;
      check({7'h0, nv_busy}, {7'h0, rows[i].busy});
      wait_idle(400);
      check(wiper_setting, rows[i].wiper);
      check(powerup_value_store, rows[i].store);
      u_dpot_master_model.rd(8'h00, rd, ak);
      check({5'h0, ak}, 8'h07);
      check(rd, rows[i].sel[7] ? rows[i].wiper : rows[i].store);
      $display("test row %0d done", i);
    end
    // A foreign identification gets no acknowledge.
    u_dpot_master_model.start();
    u_dpot_master_model.send({~ID, 1'b0}, ak[0]);
    u_dpot_master_model.stop();
    check({7'h0, ak[0]}, 8'h00);
    $display("test wrong id done");
    // Select left at 80h; a reset must bring it back to zero.
    u_dpot_master_model.wr(8'h02, 8'h80, ak);
    do_reset();
    u_dpot_master_model.wr(8'h00, 8'h5A, ak);
    u_dpot_master_model.wr(8'h00, 8'h11, ak);
    check({5'h0, ak}, 8'h00);
    wait_idle(400);
    check(powerup_value_store, 8'h5A);
    check(wiper_setting, 8'h5A);
    $display("test busy window done");
    print_verdict();
  end
endmodule : tb_dpot_slave
`default_nettype wire
